// *** ncsr_defines.vh ***
// constants shared by the network card shared-ram control block
`ifndef NCSR_DEFINES_VH
`define NCSR_DEFINES_VH

// ==========================================================
// clock and timing
`define NCSR_CLK_MHZ          25
`define NCSR_CLK_KHZ          25000
`define NCSR_SYSRST_MIN_MS    50
`define NCSR_SYSRST_CYCLES    (`NCSR_SYSRST_MIN_MS * `NCSR_CLK_KHZ)
`define NCSR_CA_PULSE_NS      200
`define NCSR_CA_PULSE_CYCLES  ((`NCSR_CA_PULSE_NS * `NCSR_CLK_MHZ + 999) / 1000)

// ==========================================================
// control register field positions
`define NCSR_CTRL_RESET_BIT     0
`define NCSR_CTRL_LOOPBACK_BIT  1
`define NCSR_CTRL_ATTENTION_BIT 2
`define NCSR_CTRL_INTCLR_BIT    3
`define NCSR_CTRL_RESET_RST     1'b1
`define NCSR_CTRL_LOOPBACK_RST  1'b0

// ==========================================================
// card address map (word address bits 13..2)
`define NCSR_ADDR_HALF_BIT   13
`define NCSR_ADDR_REGION_HI  12
`define NCSR_ADDR_REGION_LO  11
`define NCSR_REGION_ID       2'h0
`define NCSR_REGION_PAGE     2'h1
`define NCSR_REGION_CTRL     2'h2

// ==========================================================
// access sequencer states
`define NCSR_ST_IDLE    2'h0
`define NCSR_ST_PHASE1  2'h1
`define NCSR_ST_PHASE2  2'h2
`define NCSR_ST_PHASE3  2'h3

`endif

// *** ncsr_ctrl_reg.v ***
// write-only card control register with attention pulse and interrupt flag
`timescale 1ns/1ps
`include "ncsr_defines.vh"

module ncsr_ctrl_reg #(
	parameter CA_PULSE_CYCLES = `NCSR_CA_PULSE_CYCLES
) (
	input  wire       clk_in,
	input  wire       rst_in,
	input  wire       ce_in,
	input  wire       wr_in,
	input  wire [3:0] data_in,
	input  wire       coproc_int_in,
	output wire       coproc_reset_out,
	output wire       loopback_select_out,
	output wire       channel_attention_out,
	output wire       card_interrupt_n_out
);

	reg        reset_bit_reg;
	reg        loopback_bit_reg;
	reg  [7:0] ca_count_reg;
	reg        int_flag_reg;
	reg        coproc_int_prev_reg;
	wire       int_rise;

	assign int_rise = coproc_int_in & ~coproc_int_prev_reg;

	// ==========================================================
	// control bits; every write loads the reset and loopback fields at once
	always @(posedge clk_in) begin
		if (rst_in) begin
			reset_bit_reg       <= `NCSR_CTRL_RESET_RST;
			loopback_bit_reg    <= `NCSR_CTRL_LOOPBACK_RST;
			ca_count_reg        <= 8'h00;
			int_flag_reg        <= 1'b0;
			coproc_int_prev_reg <= 1'b0;
		end else if (ce_in) begin
			coproc_int_prev_reg <= coproc_int_in;
			if (wr_in) begin
				reset_bit_reg    <= data_in[`NCSR_CTRL_RESET_BIT];
				loopback_bit_reg <= data_in[`NCSR_CTRL_LOOPBACK_BIT];
			end
			if (wr_in && data_in[`NCSR_CTRL_ATTENTION_BIT])
				ca_count_reg <= CA_PULSE_CYCLES[7:0];
			else if (ca_count_reg != 8'h00)
				ca_count_reg <= ca_count_reg - 8'h01;
			// a coprocessor interrupt in the clearing cycle still wins
			if (int_rise)
				int_flag_reg <= 1'b1;
			else if (wr_in && data_in[`NCSR_CTRL_INTCLR_BIT])
				int_flag_reg <= 1'b0;
		end
	end

	assign coproc_reset_out      = reset_bit_reg;
	assign loopback_select_out   = loopback_bit_reg;
	assign channel_attention_out = (ca_count_reg != 8'h00);
	assign card_interrupt_n_out  = ~int_flag_reg;

endmodule

// *** ncsr_sysrst_drv.v ***
// open-collector system reset driver with minimum hold time
`timescale 1ns/1ps
`include "ncsr_defines.vh"

module ncsr_sysrst_drv #(
	parameter HOLD_CYCLES = `NCSR_SYSRST_CYCLES
) (
	input  wire clk_in,
	input  wire rst_in,
	input  wire ce_in,
	input  wire request_in,
	output wire sys_reset_n_out,
	output wire sys_reset_n_oe_out
);

	reg [23:0] hold_count_reg;

	// ==========================================================
	// once started the hold cannot be cut short by a new request
	always @(posedge clk_in) begin
		if (rst_in)
			hold_count_reg <= 24'h00_0000;
		else if (ce_in) begin
			if (hold_count_reg != 24'h00_0000)
				hold_count_reg <= hold_count_reg - 24'h00_0001;
			else if (request_in)
				hold_count_reg <= HOLD_CYCLES[23:0];
		end
	end

	// the line is only ever pulled low, never driven high
	assign sys_reset_n_out    = 1'b0;
	assign sys_reset_n_oe_out = (hold_count_reg != 24'h00_0000);

endmodule

// *** ncsr_top.v ***
// network card shared-ram control: host access sequencer, decode and control
`timescale 1ns/1ps
`include "ncsr_defines.vh"

// Behaviour
// - reset bit set at reset or write one
// - writing zero releases coprocessor from reset
// - loopback bit follows writes, cleared at reset
// - attention bit one emits one timed pulse
// - interrupt-clear bit one drops flag and line
// - upper twelve data bits are ignored
// - upper half RAM, lower half id/page/control
// - coprocessor fetches command on attention
// - coprocessor bus request wired to its grant
// - host access withdraws coprocessor ready
// - system reset held low at least 50ms
// - four-state sequencer on bus clock falling edge
// - idle gives buffers to coprocessor, waits select
// - phase one swaps buffers, blocks RAM writes
// - phase two performs the host access

module ncsr_top #(
	parameter SYSRST_HOLD_CYCLES = `NCSR_SYSRST_CYCLES,
	parameter CA_PULSE_CYCLES    = `NCSR_CA_PULSE_CYCLES
) (
	// clock, reset, enable
	input  wire        CLOCK_IN,
	input  wire        SRST_IN,
	input  wire        CE_IN,

	// system reset line (open collector)
	input  wire        SYS_RESET_N_IN,
	output wire        SYS_RESET_N_OUT,
	output wire        SYS_RESET_N_OE_OUT,
	input  wire        RESET_REQUEST_IN,

	// expansion card bus
	input  wire        EXPANSION_BUS_CLOCK_IN,
	input  wire        CARD_SELECT_N_IN,
	input  wire        READ_NOT_WRITE_IN,
	input  wire [13:2] ADDR_IN,
	input  wire [15:0] DATA_IN,
	output wire        CARD_INTERRUPT_N_OUT,

	// shared buffer and device enables
	output wire        HOST_BUF_EN_OUT,
	output wire        COPROC_BUF_EN_OUT,
	output wire        BUFFER_WRITE_STROBE_N_OUT,
	output wire        RAM_OUTPUT_ENABLE_OUT,
	output wire        ID_OUTPUT_ENABLE_OUT,
	output wire        PAGE_WRITE_STROBE_OUT,

	// network coprocessor
	output wire        COPROC_RESET_OUT,
	output wire        LOOPBACK_SELECT_OUT,
	output wire        CHANNEL_ATTENTION_OUT,
	output wire        COPROC_READY_OUT,
	input  wire        COPROC_BUS_REQ_IN,
	output wire        COPROC_BUS_GRANT_OUT,
	input  wire        COPROC_INTERRUPT_IN,

	// sequencer state for observation
	output wire [1:0]  SEQ_STATE_OUT
);

	// ==========================================================
	// address decode helpers
	function is_ram;
		input [13:2] addr;
		begin
			is_ram = addr[`NCSR_ADDR_HALF_BIT];
		end
	endfunction

	function is_region;
		input [13:2] addr;
		input [1:0]  region;
		begin
			is_region = ~addr[`NCSR_ADDR_HALF_BIT] &&
			            (addr[`NCSR_ADDR_REGION_HI:`NCSR_ADDR_REGION_LO] == region);
		end
	endfunction

	// ==========================================================
	// reset and bus clock edge detect
	localparam ST_IDLE   = `NCSR_ST_IDLE;
	localparam ST_PHASE1 = `NCSR_ST_PHASE1;
	localparam ST_PHASE2 = `NCSR_ST_PHASE2;
	localparam ST_PHASE3 = `NCSR_ST_PHASE3;

	reg         bus_clk_prev_reg;
	reg  [1:0]  state_reg;
	reg  [1:0]  state_next;
	reg  [13:2] addr_reg;
	reg         rnw_reg;
	wire        hard_rst;
	wire        advance;
	wire        ctrl_wr;
	wire        page_wr;
	wire        ram_sel;
	wire        id_sel;
	wire        page_sel;
	wire        ctrl_sel;
	wire        write_phase;
	wire        take_access;
	wire [3:0]  ctrl_data;
	reg         host_buf_en;
	reg         coproc_buf_en;
	reg         coproc_ready;
	reg         write_strobe;
	reg         ram_oe;
	reg         id_oe;

	// ==========================================================
	// hard reset
	// the card treats the shared system reset like its own hard reset everywhere but in the system reset driver
	assign hard_rst = SRST_IN | ~SYS_RESET_N_IN;

	// inputs are synchronous, so a sampled copy is enough for edge finding
	assign advance = CE_IN & bus_clk_prev_reg & ~EXPANSION_BUS_CLOCK_IN;

	always @(posedge CLOCK_IN) begin
		if (hard_rst)
			bus_clk_prev_reg <= 1'b0;
		else if (CE_IN)
			bus_clk_prev_reg <= EXPANSION_BUS_CLOCK_IN;
	end

	// ==========================================================
	// access sequencer
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (!CARD_SELECT_N_IN)
					state_next = ST_PHASE1;
			end
			ST_PHASE1: begin
				state_next = ST_PHASE2;
			end
			ST_PHASE2: begin
				state_next = ST_PHASE3;
			end
			ST_PHASE3: begin
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always @(posedge CLOCK_IN) begin
		if (hard_rst)
			state_reg <= ST_IDLE;
		else if (advance)
			state_reg <= state_next;
	end

	// ==========================================================
	// access capture
	// address and direction are frozen when idle takes the access
	assign take_access = advance & (state_reg == ST_IDLE) & ~CARD_SELECT_N_IN;

	always @(posedge CLOCK_IN) begin
		if (hard_rst) begin
			addr_reg <= 12'h000;
			rnw_reg  <= 1'b1;
		end else if (take_access) begin
			addr_reg <= ADDR_IN;
			rnw_reg  <= READ_NOT_WRITE_IN;
		end
	end

	// ==========================================================
	// address decode of the captured access
	assign ram_sel  = is_ram(addr_reg);
	assign id_sel   = is_region(addr_reg, `NCSR_REGION_ID);
	assign page_sel = is_region(addr_reg, `NCSR_REGION_PAGE);
	assign ctrl_sel = is_region(addr_reg, `NCSR_REGION_CTRL);

	// ==========================================================
	// device enables per sequencer phase
	// safe values first, so no phase can leave an enable undriven
	always @* begin
		host_buf_en   = 1'b0;
		coproc_buf_en = 1'b1;
		coproc_ready  = 1'b1;
		write_strobe  = 1'b0;
		ram_oe        = 1'b0;
		id_oe         = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				// coprocessor owns the buffers while the host is away
				host_buf_en   = 1'b0;
				coproc_buf_en = 1'b1;
				coproc_ready  = 1'b1;
			end
			ST_PHASE1: begin
				// write strobe held off while the buffers swap over
				host_buf_en   = 1'b1;
				coproc_buf_en = 1'b0;
				coproc_ready  = 1'b0;
				write_strobe  = 1'b0;
			end
			ST_PHASE2: begin
				// the host access itself
				host_buf_en   = 1'b1;
				coproc_buf_en = 1'b0;
				coproc_ready  = 1'b0;
				write_strobe  = ~rnw_reg & ram_sel;
				ram_oe        = rnw_reg & ram_sel;
				id_oe         = rnw_reg & id_sel;
			end
			ST_PHASE3: begin
				// buffers stay with the host through phase three to keep data stable
				host_buf_en   = 1'b1;
				coproc_buf_en = 1'b0;
				coproc_ready  = 1'b0;
			end
			default: begin
				// unused codes fall back to idle values
				host_buf_en   = 1'b0;
				coproc_buf_en = 1'b1;
				coproc_ready  = 1'b1;
			end
		endcase
	end

	assign HOST_BUF_EN_OUT           = host_buf_en;
	assign COPROC_BUF_EN_OUT         = coproc_buf_en;
	assign BUFFER_WRITE_STROBE_N_OUT = ~write_strobe;
	assign RAM_OUTPUT_ENABLE_OUT     = ram_oe;
	assign ID_OUTPUT_ENABLE_OUT      = id_oe;

	// ==========================================================
	// register writes
	// they land on the single cycle that leaves phase two
	assign write_phase = advance & (state_reg == ST_PHASE2) & ~rnw_reg;
	assign page_wr     = write_phase & page_sel;
	assign ctrl_wr     = write_phase & ctrl_sel;

	assign PAGE_WRITE_STROBE_OUT = page_wr;

	// ==========================================================
	// coprocessor arbitration
	// the coprocessor always owns its bus; host cycles only stretch it
	assign COPROC_BUS_GRANT_OUT = COPROC_BUS_REQ_IN;
	assign COPROC_READY_OUT     = coproc_ready;

	// ==========================================================
	// sequencer state made visible for observation
	assign SEQ_STATE_OUT = state_reg;

	// ==========================================================
	// control register
	// only data bits 3..0 reach the register; the rest are dropped
	assign ctrl_data = DATA_IN[3:0];

	ncsr_ctrl_reg #(
		.CA_PULSE_CYCLES (CA_PULSE_CYCLES)
	) u_ctrl (
		.clk_in                (CLOCK_IN),
		.rst_in                (hard_rst),
		.ce_in                 (CE_IN),
		.wr_in                 (ctrl_wr),
		.data_in               (ctrl_data),
		.coproc_int_in         (COPROC_INTERRUPT_IN),
		.coproc_reset_out      (COPROC_RESET_OUT),
		.loopback_select_out   (LOOPBACK_SELECT_OUT),
		.channel_attention_out (CHANNEL_ATTENTION_OUT),
		.card_interrupt_n_out  (CARD_INTERRUPT_N_OUT)
	);

	// ==========================================================
	// system reset driver
	// counted on the local clock so the minimum hold is independent of the bus
	ncsr_sysrst_drv #(
		.HOLD_CYCLES (SYSRST_HOLD_CYCLES)
	) u_sysrst (
		.clk_in             (CLOCK_IN),
		.rst_in             (SRST_IN),
		.ce_in              (CE_IN),
		.request_in         (RESET_REQUEST_IN),
		.sys_reset_n_out    (SYS_RESET_N_OUT),
		.sys_reset_n_oe_out (SYS_RESET_N_OE_OUT)
	);

endmodule

// *** ncsr_top_props.sv ***
// port checker for the shared-ram control block
`timescale 1ns/1ps
module ncsr_top_props #(
	parameter SYSRST_HOLD_CYCLES = 20,
	parameter CA_PULSE_CYCLES    = 5
) (
	// clock and resets
	input wire       CLOCK_IN,
	input wire       SRST_IN,
	input wire       SYS_RESET_N_IN,
	input wire       SYS_RESET_N_OUT,
	input wire       SYS_RESET_N_OE_OUT,
	// sequencer and enables
	input wire [1:0] SEQ_STATE_OUT,
	input wire       HOST_BUF_EN_OUT,
	input wire       COPROC_BUF_EN_OUT,
	input wire       BUFFER_WRITE_STROBE_N_OUT,
	input wire       RAM_OUTPUT_ENABLE_OUT,
	input wire       ID_OUTPUT_ENABLE_OUT,
	// coprocessor side
	input wire       COPROC_RESET_OUT,
	input wire       CHANNEL_ATTENTION_OUT,
	input wire       COPROC_READY_OUT,
	input wire       COPROC_BUS_REQ_IN,
	input wire       COPROC_BUS_GRANT_OUT,
	input wire       COPROC_INTERRUPT_IN,
	input wire       CARD_INTERRUPT_N_OUT
);
	// ==========================================================
	// assertions
	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (SRST_IN);
	AST_READY: assert property (COPROC_READY_OUT == (SEQ_STATE_OUT == 2'h0))
		else $error("coprocessor ready wrong for sequencer state");
	AST_BUFFERS: assert property (COPROC_BUF_EN_OUT == (SEQ_STATE_OUT == 2'h0) && HOST_BUF_EN_OUT != COPROC_BUF_EN_OUT)
		else $error("buffer enables wrong for sequencer state");
	AST_PH1_QUIET: assert property (SEQ_STATE_OUT == 2'h1 |-> BUFFER_WRITE_STROBE_N_OUT && !RAM_OUTPUT_ENABLE_OUT && !ID_OUTPUT_ENABLE_OUT)
		else $error("device enabled during first phase");
	AST_PH2_ONLY: assert property (!BUFFER_WRITE_STROBE_N_OUT || RAM_OUTPUT_ENABLE_OUT || ID_OUTPUT_ENABLE_OUT |-> SEQ_STATE_OUT == 2'h2)
		else $error("device enabled outside second phase");
	AST_STEP: assert property (SEQ_STATE_OUT != $past(SEQ_STATE_OUT) && SYS_RESET_N_IN && $past(SYS_RESET_N_IN) |-> SEQ_STATE_OUT == $past(SEQ_STATE_OUT) + 2'h1)
		else $error("sequencer skipped a state");
	AST_GRANT: assert property (COPROC_BUS_GRANT_OUT == COPROC_BUS_REQ_IN)
		else $error("bus grant does not follow bus request");
	AST_CA_WIDTH: assert property ($rose(CHANNEL_ATTENTION_OUT) |-> CHANNEL_ATTENTION_OUT[*5] ##1 !CHANNEL_ATTENTION_OUT)
		else $error("attention pulse width wrong");
	AST_HOLD: assert property ($rose(SYS_RESET_N_OE_OUT) |-> (SYS_RESET_N_OE_OUT && !SYS_RESET_N_OUT)[*8])
		else $error("system reset released early");
	AST_INT_SET: assert property ($rose(COPROC_INTERRUPT_IN) |-> ##[1:3] !CARD_INTERRUPT_N_OUT)
		else $error("card interrupt not raised");
	AST_HARD_RST: assert property ($fell(SYS_RESET_N_IN) |-> ##[1:3] COPROC_RESET_OUT)
		else $error("hard reset did not hold coprocessor");
endmodule

bind ncsr_top ncsr_top_props #(.SYSRST_HOLD_CYCLES(SYSRST_HOLD_CYCLES), .CA_PULSE_CYCLES(CA_PULSE_CYCLES)) u_props (
	.CLOCK_IN(CLOCK_IN), .SRST_IN(SRST_IN), .SYS_RESET_N_IN(SYS_RESET_N_IN), .SYS_RESET_N_OUT(SYS_RESET_N_OUT),
	.SYS_RESET_N_OE_OUT(SYS_RESET_N_OE_OUT), .SEQ_STATE_OUT(SEQ_STATE_OUT), .HOST_BUF_EN_OUT(HOST_BUF_EN_OUT),
	.COPROC_BUF_EN_OUT(COPROC_BUF_EN_OUT), .BUFFER_WRITE_STROBE_N_OUT(BUFFER_WRITE_STROBE_N_OUT),
	.RAM_OUTPUT_ENABLE_OUT(RAM_OUTPUT_ENABLE_OUT), .ID_OUTPUT_ENABLE_OUT(ID_OUTPUT_ENABLE_OUT),
	.COPROC_RESET_OUT(COPROC_RESET_OUT), .CHANNEL_ATTENTION_OUT(CHANNEL_ATTENTION_OUT),
	.COPROC_READY_OUT(COPROC_READY_OUT), .COPROC_BUS_REQ_IN(COPROC_BUS_REQ_IN),
	.COPROC_BUS_GRANT_OUT(COPROC_BUS_GRANT_OUT), .COPROC_INTERRUPT_IN(COPROC_INTERRUPT_IN),
	.CARD_INTERRUPT_N_OUT(CARD_INTERRUPT_N_OUT));

// *** ncsr_host_model.sv ***
// host-side expansion bus model: bus clock, select, address and data
`timescale 1ns/1ps
module ncsr_host_model (
	// clock and sequencer observation
	input  wire        clk_in,
	input  wire [1:0]  state_in,
	// expansion card bus
	output reg         bus_clk_out = 1'b1,
	output reg         sel_n_out,
	output reg         rnw_out,
	output reg  [13:2] addr_out,
	output reg  [15:0] data_out
);
	reg [5:0] acc = 6'h00;
	initial begin
		sel_n_out = 1'b1;
		rnw_out = 1'b1;
		addr_out = 12'h000;
		data_out = 16'h0000;
	end
	// ==========================================================
	// bus clock: steps of 16 out of 50 give 8 MHz from 25 MHz
	always @(negedge clk_in) begin
		acc <= (acc >= 6'd34) ? acc - 6'd34 : acc + 6'd16;
		bus_clk_out <= (acc < 6'd25);
	end
	// ==========================================================
	// one access; caller supplies direction, address and data, the task drives select
	task access(input r, input [13:2] a, input [15:0] d);
		integer i;
		begin
			@(negedge clk_in);
			rnw_out = r;
			addr_out = a;
			data_out = d;
			sel_n_out = 1'b0;
			for (i = 0; i < 20 && state_in == 2'h0; i = i + 1) @(negedge clk_in);
			// select dropped once taken, else idle would start a second access
			sel_n_out = 1'b1;
			for (i = 0; i < 40 && state_in != 2'h0; i = i + 1) @(negedge clk_in);
			addr_out = ~a;
			data_out = ~d;
		end
	endtask
endmodule

// *** ncsr_top_bench.sv ***
// self-checking bench for the shared-ram control block
`timescale 1ns/1ps
module ncsr_top_bench;
	reg         clk = 0, srst = 1, req = 0, breq = 0, cint = 0, ce = 1;
	reg  [3:0]  seen = 0;
	wire        oe, bclk, sel_n, rnw, ca, we_n, ram_oe, id_oe, pg, crst, lb, rdy, gnt, int_n, hbuf, cbuf, drv_n;
	wire [1:0]  st;
	wire [13:2] addr;
	wire [15:0] data;
	wire        sys_n = ~oe;
	integer     n_errors = 0, checked = 0, cyc = 0, ca_n = 0, oe_n = 0;
	always #20 clk = ~clk;
	ncsr_host_model host (.clk_in(clk), .state_in(st), .bus_clk_out(bclk), .sel_n_out(sel_n), .rnw_out(rnw),
		.addr_out(addr), .data_out(data));
	ncsr_top #(.SYSRST_HOLD_CYCLES(20), .CA_PULSE_CYCLES(5)) dut (.CLOCK_IN(clk), .SRST_IN(srst), .CE_IN(ce),
		.SYS_RESET_N_IN(sys_n), .SYS_RESET_N_OUT(drv_n), .SYS_RESET_N_OE_OUT(oe), .RESET_REQUEST_IN(req),
		.EXPANSION_BUS_CLOCK_IN(bclk), .CARD_SELECT_N_IN(sel_n), .READ_NOT_WRITE_IN(rnw), .ADDR_IN(addr),
		.DATA_IN(data), .CARD_INTERRUPT_N_OUT(int_n), .HOST_BUF_EN_OUT(hbuf), .COPROC_BUF_EN_OUT(cbuf),
		.BUFFER_WRITE_STROBE_N_OUT(we_n), .RAM_OUTPUT_ENABLE_OUT(ram_oe), .ID_OUTPUT_ENABLE_OUT(id_oe),
		.PAGE_WRITE_STROBE_OUT(pg), .COPROC_RESET_OUT(crst), .LOOPBACK_SELECT_OUT(lb),
		.CHANNEL_ATTENTION_OUT(ca), .COPROC_READY_OUT(rdy), .COPROC_BUS_REQ_IN(breq),
		.COPROC_BUS_GRANT_OUT(gnt), .COPROC_INTERRUPT_IN(cint), .SEQ_STATE_OUT(st));
	// ==========================================================
	// monitors and timeout
	always @(posedge clk) begin
		cyc <= cyc + 1;
		ca_n <= ca_n + (ca ? 1 : 0);
		oe_n <= oe_n + (oe ? 1 : 0);
		seen <= seen | {~we_n, ram_oe, id_oe, pg};
		if (cyc == 3000) begin
			n_errors = n_errors + 1;
			final_report;
		end
	end
	task chk(input [255:0] name, input [15:0] exp, input [15:0] got);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("FAIL %0s expected %h seen %h", name, exp, got);
			end
		end
	endtask
	// access, then let a full attention pulse finish
	task go(input r, input [13:2] a, input [15:0] d);
		begin
			seen = 4'h0;
			ca_n = 0;
			host.access(r, a, d);
			repeat (8) @(negedge clk);
		end
	endtask
	task final_report;
		begin
			$display("checked %0d n_errors %0d", checked, n_errors);
			if (n_errors == 0 && checked > 0) begin
				$display("Regression OK");
			end else begin
				$display("Regression broken");
			end
			$finish;
		end
	endtask
	// ==========================================================
	// tests; control register sits at 12'h400, buffer RAM at 12'h800
	initial begin
		repeat (20) @(negedge clk);
		srst = 0;
		chk("reset outs", 7'b1001110, {crst, lb, ca, int_n, rdy, cbuf, hbuf});
		go(1'b0, 12'h400, 16'hfff2);
		chk("reset loop", 2'b01, {crst, lb});
		chk("no pulse", 0, ca_n[15:0]);
		go(1'b0, 12'h800, 16'h1234);
		chk("ram write", 4'b1000, seen);
		chk("ready back", 3'b110, {rdy, cbuf, hbuf});
		go(1'b0, 12'h400, 16'h0006);
		chk("ca pulse", 5, ca_n[15:0]);
		chk("ctrl kept", 2'b01, {crst, lb});
		go(1'b1, 12'h800, 16'h0000);
		chk("ram read", 4'b0100, seen);
		go(1'b1, 12'h000, 16'h0000);
		chk("id read", 4'b0010, seen);
		go(1'b0, 12'h200, 16'h0005);
		chk("page write", 4'b0001, {seen[3:1], seen[0]});
		go(1'b0, 12'h600, 16'h0001);
		chk("unused region", 6'b000001, {seen, crst, lb});
		cint = 1;
		repeat (4) @(negedge clk);
		chk("int set", 0, int_n);
		go(1'b0, 12'h400, 16'h0002);
		chk("int kept", 0, int_n);
		go(1'b0, 12'h400, 16'h000a);
		chk("int cleared", 3'b101, {int_n, crst, lb});
		breq = 1;
		@(negedge clk);
		chk("grant", 1, gnt);
		ce = 0;
		req = 1;
		repeat (3) @(negedge clk);
		chk("frozen", 0, oe);
		ce = 1;
		repeat (5) @(negedge clk);
		req = 0;
		repeat (30) @(negedge clk);
		chk("hold cycles", 20, oe_n[15:0]);
		chk("hard reset", 2'b10, {crst, lb});
		final_report;
	end
endmodule
